// >>> common/spms_consts.svh
// Register map, field positions, reset values and timing for the SPI port.
`ifndef SPMS_CONSTS_SVH
`define SPMS_CONSTS_SVH
`define SPMS_ADDR_CTRL 2'h0
`define SPMS_ADDR_STAT 2'h1
`define SPMS_ADDR_DATA 2'h2
`define SPMS_ADDR_DIR  2'h3
`define SPMS_CTL_IE    7
`define SPMS_CTL_EN    6
`define SPMS_CTL_LSB   5
`define SPMS_CTL_MST   4
`define SPMS_CTL_CLOCK_IDLE_POLARITY  3
`define SPMS_CTL_CLOCK_PHASE_SELECT  2
`define SPMS_DIR_MOSI  0
`define SPMS_DIR_MISO  1
`define SPMS_DIR_SCK   2
`define SPMS_DIR_SS    3
`define SPMS_DIR_SSLVL 4
`define SPMS_RST_CTRL  8'h00
`define SPMS_RST_DIR   5'h00
`define SPMS_EDGES     5'h10
`endif

// >>> common/spms_pkg.sv
// Types shared by the SPI port design.
package spms_pkg;
  // Complete state of the port, registered as one word.
  typedef struct packed {
    logic [7:0] ctrl;   // Control register.
    logic       dbl;    // Double speed bit.
    logic       done;   // transfer_done_flag.
    logic       write_collision_flag;   // write_collision_flag.
    logic       armed;  // Status was read with a flag set.
    logic [4:0] dir;    // Pin directions and SS output level.
    logic [7:0] sh;     // Shift register.
    logic [7:0] rxb;    // Receive buffer.
    logic [4:0] cnt;    // SCK edges seen in this byte.
    logic       samp;   // Bit caught on the sample edge.
    logic       run;    // Master clock generator running.
    logic [6:0] div;    // Master half-period counter.
    logic       sck_t;  // Master SCK, relative to idle level.
    logic [2:0] sck_s;  // SCK sync stages and previous value.
    logic [2:0] ss_s;   // SS sync stages and previous value.
    logic [1:0] mosi_s; // MOSI sync stages.
    logic [7:0] rdata;  // Read data.
    logic       irq;    // Interrupt request.
    logic       mosi_o;
    logic       mosi_oe;
    logic       miso_o;
    logic       miso_oe;
    logic       sck_o;
    logic       sck_oe;
    logic       ss_o;
    logic       ss_oe;
  } spms_state_t;
endpackage : spms_pkg

// >>> hw/spms_port.sv
// SPI master/slave port with register access and pin direction control.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "spms_consts.svh"
module spms_port (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       global_irq_enable,
  input  wire logic       irq_ack,
  output var  logic       irq_req,
  input  wire logic       mosi_i,
  output var  logic       mosi_o,
  output var  logic       mosi_oe,
  input  wire logic       miso_i,
  output var  logic       miso_o,
  output var  logic       miso_oe,
  input  wire logic       sck_i,
  output var  logic       sck_o,
  output var  logic       sck_oe,
  input  wire logic       ss_n_i,
  output var  logic       ss_n_o,
  output var  logic       ss_n_oe
);
  import spms_pkg::*;

  spms_state_t s_q;  // Registered state.
  spms_state_t s_d;  // Next state.

  // Picks the bit that leaves the shift register first.
  function automatic logic tx_bit(input logic [7:0] sh, input logic lsb);
    tx_bit = lsb ? sh[0] : sh[7];
  endfunction : tx_bit

  // Shifts one received bit in at the end opposite the outgoing bit.
  function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                          input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction : shift_in

  logic       en;       // Port enabled.
  logic       mst;      // Master role.
  logic       clock_idle_polarity;     // Idle level of SCK.
  logic       clock_phase_select;     // Phase select.
  logic       lsb;      // LSB first.
  logic       slv;      // Selected slave.
  logic       ss_rise;  // Synchronised SS went high.
  logic       force_s;  // Another master selected us.
  logic       edge_e;   // One SCK edge to act on.
  logic       lead;     // That edge is the leading one.
  logic       din;      // Incoming serial bit.
  logic       busy;     // A byte is being shifted.
  logic       data_acc; // Data register accessed.
  logic [6:0] half;     // Master half period minus one.
  logic [7:0] fin;      // Completed received byte.

  // Next-state logic for the whole port.
  always_comb
  begin
    s_d = s_q;
    en = s_q.ctrl[`SPMS_CTL_EN];
    mst = s_q.ctrl[`SPMS_CTL_MST];
    clock_idle_polarity = s_q.ctrl[`SPMS_CTL_CLOCK_IDLE_POLARITY];
    clock_phase_select = s_q.ctrl[`SPMS_CTL_CLOCK_PHASE_SELECT];
    lsb = s_q.ctrl[`SPMS_CTL_LSB];
    edge_e = 1'b0;
    lead = 1'b0;
    fin = s_q.sh;
    // Two flops each on SCK, SS and MOSI, none on MISO; edges are judged only on the second stage.
    s_d.sck_s = {s_q.sck_s[1:0], sck_i};
    s_d.ss_s = {s_q.ss_s[1:0], ss_n_i};
    s_d.mosi_s = {s_q.mosi_s[0], mosi_i};
    slv = en && !mst && !s_q.ss_s[1];
    ss_rise = s_q.ss_s[1] && !s_q.ss_s[2];
    force_s = en && mst && !s_q.dir[`SPMS_DIR_SS] && !s_q.ss_s[1];
    busy = s_q.run || (s_q.cnt != 5'h00);
    data_acc = (reg_wr || reg_rd) && (reg_addr == `SPMS_ADDR_DATA);
    din = mst ? miso_i : s_q.mosi_s[1];
    // Half period from the rate bits; double speed halves it.
    unique case (s_q.ctrl[1:0])
      2'h0:    half = s_q.dbl ? 7'h00 : 7'h01;
      2'h1:    half = s_q.dbl ? 7'h03 : 7'h07;
      2'h2:    half = s_q.dbl ? 7'h0f : 7'h1f;
      default: half = s_q.dbl ? 7'h1f : 7'h3f;
    endcase
    // Flag clearing comes first so that a coinciding set wins.
    if (irq_ack)
    begin
      s_d.done = 1'b0;
    end
    if (data_acc && s_q.armed)
    begin
      s_d.done = 1'b0;
      s_d.write_collision_flag = 1'b0;
      s_d.armed = 1'b0;
    end
    if (reg_rd && reg_addr == `SPMS_ADDR_STAT && (s_q.done || s_q.write_collision_flag))
    begin
      s_d.armed = 1'b1;
    end
    // Master clock generator: toggle SCK every half period.
    if (en && mst && s_q.run)
    begin
      if (s_q.div == half)
      begin
        s_d.div = 7'h00;
        s_d.sck_t = ~s_q.sck_t;
        edge_e = 1'b1;
        lead = !s_q.sck_t;
      end
      else
      begin
        s_d.div = s_q.div + 7'h01;
      end
    end
    // Selected slave acts on synchronised SCK edges only.
    else if (slv && (s_q.sck_s[1] ^ s_q.sck_s[2]))
    begin
      edge_e = 1'b1;
      lead = (s_q.sck_s[1] != clock_idle_polarity);
    end
    // Sample on one edge, shift on the other, as the mode asks.
    if (edge_e)
    begin
      s_d.cnt = s_q.cnt + 5'h01;
      if (lead ^ clock_phase_select)
      begin
        s_d.samp = din;
      end
      else if (!(clock_phase_select && s_q.cnt == 5'h00))
      begin
        s_d.sh = shift_in(s_q.sh, lsb, s_q.samp);
      end
      if (s_d.cnt == `SPMS_EDGES)
      begin
        fin = clock_phase_select ? shift_in(s_q.sh, lsb, din) : s_d.sh;
        s_d.sh = fin;
        s_d.rxb = fin;
        s_d.done = 1'b1;
        s_d.run = 1'b0;
        s_d.cnt = 5'h00;
        s_d.div = 7'h00;
      end
    end
    // Deselecting a slave restarts the byte and drops partial bits.
    if (en && !mst && ss_rise)
    begin
      s_d.cnt = 5'h00;
      s_d.sh = 8'h00;
      s_d.samp = 1'b0;
    end
    // Another master pulled SS low: step down to slave.
    if (force_s)
    begin
      s_d.ctrl[`SPMS_CTL_MST] = 1'b0;
      s_d.done = 1'b1;
      s_d.run = 1'b0;
      s_d.cnt = 5'h00;
      s_d.div = 7'h00;
      s_d.sck_t = 1'b0;
    end
    // Register writes.
    if (reg_wr)
    begin
      unique case (reg_addr)
        `SPMS_ADDR_CTRL: s_d.ctrl = reg_wdata;
        `SPMS_ADDR_STAT: s_d.dbl = reg_wdata[0];
        `SPMS_ADDR_DIR:  s_d.dir = reg_wdata[4:0];
        default:
        begin
          // Only one transmit byte: a write during a transfer is refused.
          if (busy)
          begin
            s_d.write_collision_flag = 1'b1;
          end
          else
          begin
            s_d.sh = reg_wdata;
            if (en && mst && !force_s)
            begin
              s_d.run = 1'b1;
              s_d.cnt = 5'h00;
              s_d.div = 7'h00;
            end
          end
        end
      endcase
    end
    // Read data stands only in the cycle after the strobe.
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SPMS_ADDR_CTRL: s_d.rdata = s_q.ctrl;
        `SPMS_ADDR_STAT: s_d.rdata = {s_q.done, s_q.write_collision_flag, 5'h00, s_q.dbl};
        `SPMS_ADDR_DIR:  s_d.rdata = {3'h0, s_q.dir};
        default:         s_d.rdata = s_q.rxb;
      endcase
    end
    // Pins follow the new state so outputs come straight from flops.
    if (s_d.ctrl[`SPMS_CTL_EN])
    begin
      s_d.mosi_oe = s_d.ctrl[`SPMS_CTL_MST] && s_d.dir[`SPMS_DIR_MOSI];
      s_d.sck_oe = s_d.ctrl[`SPMS_CTL_MST] && s_d.dir[`SPMS_DIR_SCK];
      s_d.ss_oe = s_d.ctrl[`SPMS_CTL_MST] && s_d.dir[`SPMS_DIR_SS];
      s_d.miso_oe = !s_d.ctrl[`SPMS_CTL_MST] && !s_d.ss_s[1]
                    && s_d.dir[`SPMS_DIR_MISO];
    end
    else
    begin
      s_d.mosi_oe = s_d.dir[`SPMS_DIR_MOSI];
      s_d.sck_oe = s_d.dir[`SPMS_DIR_SCK];
      s_d.ss_oe = s_d.dir[`SPMS_DIR_SS];
      s_d.miso_oe = s_d.dir[`SPMS_DIR_MISO];
    end
    s_d.mosi_o = tx_bit(s_d.sh, s_d.ctrl[`SPMS_CTL_LSB]);
    s_d.miso_o = s_d.mosi_o;
    s_d.sck_o = s_d.sck_t ^ s_d.ctrl[`SPMS_CTL_CLOCK_IDLE_POLARITY];
    s_d.ss_o = s_d.dir[`SPMS_DIR_SSLVL];
    s_d.irq = s_d.done && s_d.ctrl[`SPMS_CTL_IE]
              && global_irq_enable;
  end

  // One register for all state; a low clock enable freezes it.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.ctrl <= `SPMS_RST_CTRL;
      s_q.dir <= `SPMS_RST_DIR;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign irq_req = s_q.irq;
  assign mosi_o = s_q.mosi_o;
  assign mosi_oe = s_q.mosi_oe;
  assign miso_o = s_q.miso_o;
  assign miso_oe = s_q.miso_oe;
  assign sck_o = s_q.sck_o;
  assign sck_oe = s_q.sck_oe;
  assign ss_n_o = s_q.ss_o;
  assign ss_n_oe = s_q.ss_oe;

  // Checks tie pins and flags to their causes.
  chk_miso_master_in: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_q.ctrl[`SPMS_CTL_EN] && s_q.ctrl[`SPMS_CTL_MST] |-> !miso_oe)
    else $error("MISO driven in master role");

  chk_slave_pins_in: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_q.ctrl[`SPMS_CTL_EN] && !s_q.ctrl[`SPMS_CTL_MST]
    |-> !mosi_oe && !sck_oe && !ss_n_oe)
    else $error("Slave drives MOSI, SCK or SS");

  chk_slave_idle_pins: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_q.ctrl[`SPMS_CTL_EN] && !s_q.ctrl[`SPMS_CTL_MST] && s_q.ss_s[1]
    |-> !miso_oe)
    else $error("Deselected slave drives MISO");

  chk_ss_rise_clear: assert property (
    @(posedge ref_clk) disable iff (reset)
    clk_en && en && !mst && ss_rise |=> s_q.cnt == 5'h00)
    else $error("Bit counter not cleared on SS rise");

  chk_force_slave: assert property (
    @(posedge ref_clk) disable iff (reset)
    clk_en && force_s && !reg_wr
    |=> !s_q.ctrl[`SPMS_CTL_MST] && s_q.done && !s_q.run)
    else $error("No drop to slave on SS low");

  chk_write_collision_flag_on_busy: assert property (
    @(posedge ref_clk) disable iff (reset)
    clk_en && reg_wr && reg_addr == `SPMS_ADDR_DATA && busy
    |=> s_q.write_collision_flag && $stable(s_q.rxb) || s_q.done)
    else $error("Collision flag not set");

  chk_sck_idle_level: assert property (
    @(posedge ref_clk) disable iff (reset)
    clk_en && en && mst && !s_q.run
    ##1 s_q.ctrl[`SPMS_CTL_EN] && s_q.ctrl[`SPMS_CTL_MST]
    |-> sck_o == s_q.ctrl[`SPMS_CTL_CLOCK_IDLE_POLARITY])
    else $error("SCK not at idle level");

  chk_rate_div16: assert property (
    @(posedge ref_clk) disable iff (reset)
    clk_en && en && mst && s_q.run && s_q.ctrl[1:0] == 2'h1 && !s_q.dbl
    && s_q.div == 7'h07 |=> sck_o != $past(sck_o))
    else $error("SCK half period is not eight clocks");

  chk_irq_gate: assert property (
    @(posedge ref_clk) disable iff (reset)
    clk_en ##1 1'b1 |-> irq_req == (s_q.done && s_q.ctrl[`SPMS_CTL_IE]
                                   && $past(global_irq_enable)))
    else $error("Interrupt request not gated by enables");

  chk_eight_bits: assert property (
    @(posedge ref_clk) disable iff (reset)
    clk_en && edge_e && s_q.cnt == 5'h0f |=> s_q.done && s_q.cnt == 5'h00)
    else $error("Byte not completed after sixteen edges");
endmodule : spms_port
`default_nettype wire

// >>> sim/spms_slave_model.sv
// Behavioural outside SPI slave facing the port in master role.
`timescale 1ns/1ps
`default_nettype none
module spms_slave_model (
  input  wire logic       ss_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       clock_idle_polarity,
  input  wire logic       clock_phase_select,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  logic [7:0] sh_q; // Outgoing bits, first bit on top.
  logic       ss_p; // Select level seen at the last event.

  // One process owns MISO and the shift register. A change of select
  // loads a fresh byte; release shows the inverse of the last level so
  // that a stale bit never passes for data, and never an unknown.
  // An SCK edge while selected samples on one edge, presents on the other.
  always @(ss_n or sck)
    begin
      if (ss_n !== ss_p)
        begin
          sh_q = tx_byte;
          miso = ss_n ? (miso !== 1'b1) : tx_byte[7];
        end
      else if (!ss_n)
        begin
          if (sck ^ clock_idle_polarity ^ clock_phase_select)
            begin
              rx_byte = {rx_byte[6:0], mosi};
              sh_q    = {sh_q[6:0], 1'b0};
            end
          else
            miso = sh_q[7];
        end
      ss_p = ss_n;
    end
endmodule : spms_slave_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the SPI port in master and slave roles.
`timescale 1ns/1ps
`default_nettype none
`include "spms_consts.svh"
module tb_top;
  logic       ref_clk, reset, reg_wr, reg_rd, irq_ack, gie, clk_en;
  logic [1:0] reg_addr, mode;
  logic [7:0] reg_wdata, s_tx, v;
  logic       tb_mosi, tb_sck, tb_ss_n, sck_p;
  int         error_cnt, n_compared, per, cnt;
  wire  logic [7:0] reg_rdata, m_rx;
  wire  logic mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe;
  wire  logic ss_n_o, ss_n_oe, irq_req, m_miso;
  // Pin levels: the port wins where it drives, else bench or model.
  wire  logic mosi_pin = mosi_oe ? mosi_o : tb_mosi;
  wire  logic miso_pin = miso_oe ? miso_o : m_miso;
  wire  logic sck_pin  = sck_oe ? sck_o : tb_sck;
  wire  logic ss_pin   = ss_n_oe ? ss_n_o : tb_ss_n;

  spms_port spms_port_i (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_enable(gie),
    .irq_ack(irq_ack), .irq_req(irq_req), .mosi_i(mosi_pin),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_pin),
    .miso_o(miso_o), .miso_oe(miso_oe), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe(sck_oe), .ss_n_i(ss_pin), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
  spms_slave_model spms_slave_model_i (.ss_n(ss_pin), .sck(sck_pin),
    .mosi(mosi_pin), .clock_idle_polarity(mode[1]), .clock_phase_select(mode[0]), .tx_byte(s_tx),
    .miso(m_miso), .rx_byte(m_rx));

  // Free-running 20 MHz clock.
  initial
    begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
    end

  // Spacing of rising SCK edges, to check the master rate.
  // Looked at on the falling clock edge, where the pin has settled.
  always @(negedge ref_clk)
    begin
      cnt++;
      if (sck_o && !sck_p)
        begin
          per = cnt;
          cnt = 0;
        end
      sck_p = sck_o;
    end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
      begin
        error_cnt++;
        $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
  endtask : chk

  // One-cycle write strobe, entered just after a rising edge.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd

  // Polls status until the done flag shows; v keeps the last status.
  task automatic wait_done();
    v = 8'h00;
    for (int k = 0; k < 300 && !v[7]; k++)
      rd(`SPMS_ADDR_STAT, v);
    if (!v[7])
      chk(v, 8'h80);
  endtask : wait_done

  // One master byte; the slave is reselected so it reloads st.
  task automatic mx(input logic [7:0] d, input logic [7:0] st);
    s_tx <= st;
    wr(`SPMS_ADDR_DIR, 8'h1d);
    wr(`SPMS_ADDR_DIR, 8'h0d);
    wr(`SPMS_ADDR_DATA, d);
    wait_done();
  endtask : mx

  // Clocks n mode 0 bits in as an outside master, collecting MISO.
  task automatic slv(input logic [7:0] d, input int n,
                     output logic [7:0] q);
    for (int i = 7; i > 7 - n; i--)
      begin
        tb_mosi <= d[i];
        repeat (4) @(posedge ref_clk);
        tb_sck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        q = {q[6:0], miso_pin};
        tb_sck <= 1'b0;
      end
  endtask : slv

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Cuts a hang short well after the tests should have ended.
  initial
    begin
      #3000000;
      error_cnt++;
      wrap_up();
    end

  // Main sequence: modes, overrun, collision, forced drop, slave role.
  initial
    begin
      reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 2'h0;
      reg_wdata = 8'h00; irq_ack = 1'b0; gie = 1'b0; mode = 2'h0;
      tb_mosi = 1'b0; tb_sck = 1'b0; tb_ss_n = 1'b1; s_tx = 8'h00;
      clk_en = 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`SPMS_ADDR_CTRL, v);
      chk(v, 8'h00);
      wr(`SPMS_ADDR_DIR, 8'h1d);
      for (int m = 0; m < 4; m++)
        begin
          mode <= m[1:0];
          wr(`SPMS_ADDR_CTRL, 8'h51 | {4'h0, m[1:0], 2'h0});
          repeat (2) @(posedge ref_clk);
          #1 chk({7'h0, sck_o}, {7'h0, m[1]});
          chk({7'h0, miso_oe}, 8'h00);
          mx(8'h30 + m[7:0], 8'hc0 + m[7:0]);
          chk(m_rx, 8'h30 + m[7:0]);
          chk(per[7:0], 8'h10);
          rd(`SPMS_ADDR_DATA, v);
          chk(v, 8'hc0 + m[7:0]);
        end
      mx(8'h11, 8'haa);
      mx(8'h22, 8'h55);
      rd(`SPMS_ADDR_DATA, v);
      chk(v, 8'h55);
      s_tx <= 8'h00;
      wr(`SPMS_ADDR_DIR, 8'h1d);
      wr(`SPMS_ADDR_DIR, 8'h0d);
      wr(`SPMS_ADDR_DATA, 8'h44);
      wr(`SPMS_ADDR_DATA, 8'h99);
      wait_done();
      chk(v, 8'hc0);
      chk(m_rx, 8'h44);
      rd(`SPMS_ADDR_DATA, v);
      gie <= 1'b1;
      tb_ss_n <= 1'b1;
      wr(`SPMS_ADDR_DIR, 8'h1d);
      repeat (3) @(posedge ref_clk);
      wr(`SPMS_ADDR_DIR, 8'h05);
      wr(`SPMS_ADDR_CTRL, 8'hd1);
      repeat (3) @(posedge ref_clk);
      rd(`SPMS_ADDR_CTRL, v);
      chk(v, 8'hd1);
      tb_ss_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 chk({6'h0, mosi_oe, sck_oe}, 8'h00);
      chk({7'h0, irq_req}, 8'h01);
      gie <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk({7'h0, irq_req}, 8'h00);
      rd(`SPMS_ADDR_CTRL, v);
      chk(v, 8'hc1);
      irq_ack <= 1'b1;
      @(posedge ref_clk);
      irq_ack <= 1'b0;
      rd(`SPMS_ADDR_STAT, v);
      chk(v, 8'h00);
      tb_ss_n <= 1'b1;
      wr(`SPMS_ADDR_DIR, 8'h02);
      wr(`SPMS_ADDR_CTRL, 8'h40);
      wr(`SPMS_ADDR_DATA, 8'h96);
      repeat (4) @(posedge ref_clk);
      #1 chk({7'h0, miso_oe}, 8'h00);
      tb_ss_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      #1 chk({4'h0, mosi_oe, miso_oe, sck_oe, ss_n_oe}, 8'h04);
      slv(8'h5a, 8, v);
      chk(v, 8'h96);
      repeat (6) @(posedge ref_clk);
      rd(`SPMS_ADDR_STAT, v);
      chk(v, 8'h80);
      rd(`SPMS_ADDR_DATA, v);
      chk(v, 8'h5a);
      slv(8'hff, 3, v);
      tb_ss_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      tb_ss_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      slv(8'h3c, 8, v);
      repeat (6) @(posedge ref_clk);
      rd(`SPMS_ADDR_DATA, v);
      chk(v, 8'h3c);
      wr(`SPMS_ADDR_CTRL, 8'h60);
      wr(`SPMS_ADDR_DATA, 8'h01);
      slv(8'h12, 8, v);
      chk(v, 8'h80);
      repeat (6) @(posedge ref_clk);
      wr(`SPMS_ADDR_STAT, 8'h01);
      rd(`SPMS_ADDR_STAT, v);
      chk(v, 8'h81);
      rd(`SPMS_ADDR_DATA, v);
      chk(v, 8'h48);
      @(posedge ref_clk);
      #1 chk(reg_rdata, 8'h00);
      clk_en <= 1'b0;
      wr(`SPMS_ADDR_CTRL, 8'h00);
      clk_en <= 1'b1;
      rd(`SPMS_ADDR_CTRL, v);
      chk(v, 8'h60);
      wrap_up();
    end
endmodule : tb_top
`default_nettype wire
